/* File: design/sld_driver.sv */
// Segment display driver: register file, display memory, frame timing and pin drive
// Behaviour
// - Display runs four-backplane multiplexing only when multiplex field is 11.
// - Configuration bit 7 enables the driver; clear keeps it inactive.
// - Setting configuration bit 6 clears all display memory bytes.
// - Configuration bit 5 enables blinking, shaped by the blink-mode field.
// - With bit 4 set, sleep forces display off regardless of enable.
// - Blink source: 00/01 software, 10 fixed 2 Hz, 11 external off-time.
// - Frame rate derives from display clock and four-bit divider field.
// - Code 0010 gives 341.3/85.3 Hz, 1111 gives 64/16 Hz; 0001 unsupported.
// - Drive waveform inverts at twice backplane switching rate for zero DC.
// - Secondary control bit 6 inverts every other frame; clear means none.
// - Refresh-hold bit freezes display; memory is used from next frame after clear.
// - Pointer write with bit 7 set stores data register into addressed byte.
// - Memory spans 0x00..0x0C, low nibble even segment, high nibble odd.
// - Pin-sequence enable with code 110 or 111 selects pin-out order.
// - Reverse register bit 3 reverses segment output order.
// - Reverse register bit 2 reverses backplane output order.
// - Clock-select 00/01 stop display clock, 10 uses rate field, 11 gives 128 Hz.
// - After reset the shared pads default to display function.
`include "sld_params.svh"

module sld_driver
  import sld_pkg::*;
#(
  parameter int CYC_128 = `SLD_CLK_HZ / `SLD_F128_HZ,
  parameter int CYC_1024 = `SLD_CLK_HZ / `SLD_F1024_HZ,
  parameter int CYC_2048 = `SLD_CLK_HZ / `SLD_F2048_HZ,
  parameter int CYC_4096 = `SLD_CLK_HZ / `SLD_F4096_HZ,
  parameter int CYC_8192 = `SLD_CLK_HZ / `SLD_F8192_HZ,
  parameter int CYC_BLINK_HALF = `SLD_CLK_HZ / (2 * `SLD_BLINK_HZ)
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Register bus from the core
  input sld_req_t req,
  output logic [7:0] rdata,
  // Power state and external blink source
  input wire logic sleep_power_state,
  input wire logic external_blink_time,
  // Panel drive
  output logic [28:0] panel_pins,
  output logic display_active,
  output logic pads_display_fn
);

  sld_state_t st;
  sld_state_t next_st;

  logic [19:0] clk_period;
  logic tick;
  logic [5:0] half_len;
  logic half_end;
  logic frame_end;
  logic inv;
  logic vis;
  logic next_active;
  logic [3:0] com_lvl;
  logic [24:0] seg_lvl;
  logic [3:0] com_o;
  logic [24:0] seg_o;
  logic [6:0] ptr_addr;

  // ==========================================
  // Next-state logic
  always_comb begin
    next_st = st;
    clk_period = 20'h00001;
    tick = 1'b0;
    half_len = `SLD_HALF_FD0;
    half_end = 1'b0;
    frame_end = 1'b0;
    inv = 1'b0;
    vis = 1'b1;
    next_active = 1'b0;
    com_lvl = 4'h0;
    seg_lvl = 25'h0000000;
    com_o = 4'h0;
    seg_o = 25'h0000000;
    ptr_addr = req.wdata[6:0];

    // External blink pin, two-stage synchroniser
    next_st.ext_s1 = external_blink_time;
    next_st.ext_s2 = st.ext_s1;

    // Display clock source select
    unique case (st.rtc_clk[1:0])
      2'h0: clk_period = 20'(CYC_2048);
      2'h1: clk_period = 20'(CYC_1024);
      2'h2: clk_period = 20'(CYC_4096);
      default: clk_period = 20'(CYC_8192);
    endcase
    if (st.rtc_clk[3:2] == `SLD_CKSEL_128) begin
      clk_period = 20'(CYC_128);
    end
    if (st.rtc_clk[3]) begin
      if (st.clk_cnt >= clk_period - 20'h00001) begin
        next_st.clk_cnt = 20'h00000;
        tick = 1'b1;
      end else begin
        next_st.clk_cnt = st.clk_cnt + 20'h00001;
      end
    end else begin
      next_st.clk_cnt = 20'h00000;
    end

    // Half-slot length in display clocks: code 0 gives the slowest rate.
    // Code 1 is unsupported; it is run as code 2 to keep the panel safe.
    if (st.clkb[3:0] == 4'h0) begin
      half_len = `SLD_HALF_FD0;
    end else if (st.clkb[3:0] == 4'h1) begin
      half_len = 6'h03;
    end else begin
      half_len = {2'h0, st.clkb[3:0]} + 6'h01;
    end

    // Polarity flips every half slot: two flips per backplane slot
    if (tick) begin
      if (st.half_cnt >= half_len - 6'h01) begin
        next_st.half_cnt = 6'h00;
        half_end = 1'b1;
      end else begin
        next_st.half_cnt = st.half_cnt + 6'h01;
      end
    end
    if (half_end) begin
      next_st.pol = ~st.pol;
      if (st.pol) begin
        next_st.slot = st.slot + 2'h1;
        frame_end = (st.slot == 2'h3);
      end
    end
    if (frame_end) begin
      next_st.fpar = ~st.fpar;
      if (!st.ctly[`SLD_CTLY_HOLD]) begin
        next_st.shadow = st.mem;
      end
    end

    // Blink phase timer
    if (st.blink_cnt >= 25'(CYC_BLINK_HALF - 1)) begin
      next_st.blink_cnt = 25'h0000000;
      next_st.blink_vis = ~st.blink_vis;
    end else begin
      next_st.blink_cnt = st.blink_cnt + 25'h0000001;
    end
    if (st.cfg[`SLD_CFG_BLINK]) begin
      if (st.clkb[7:6] == `SLD_BLK_2HZ) begin
        vis = st.blink_vis;
      end else if (st.clkb[7:6] == `SLD_BLK_EXT) begin
        vis = ~st.ext_s2;
      end
    end

    // Register writes
    if (req.we && !req.rtc_space) begin
      unique case (req.addr)
        `SLD_OFF_CFG: begin
          // Clear bit acts once and reads back as zero
          next_st.cfg = req.wdata & `SLD_CFG_MASK & ~(8'h01 << `SLD_CFG_CLR);
          if (req.wdata[`SLD_CFG_CLR]) begin
            next_st.mem = '0;
          end
        end
        `SLD_OFF_CLKB: next_st.clkb = req.wdata & `SLD_CLKB_MASK;
        `SLD_OFF_PIN: next_st.pin = req.wdata & `SLD_PIN_MASK;
        `SLD_OFF_CONX: next_st.conx = req.wdata;
        `SLD_OFF_PTR: begin
          next_st.ptr = req.wdata;
          if (ptr_addr <= `SLD_MEM_LAST) begin
            if (req.wdata[`SLD_PTR_WR]) begin
              next_st.mem[ptr_addr[3:0]] = st.dat;
            end else begin
              next_st.dat = st.mem[ptr_addr[3:0]];
            end
          end else if (!req.wdata[`SLD_PTR_WR]) begin
            next_st.dat = 8'h00;
          end
        end
        `SLD_OFF_DAT: next_st.dat = req.wdata;
        `SLD_OFF_CTLY: next_st.ctly = req.wdata & `SLD_CTLY_MASK;
        `SLD_OFF_REV: next_st.rev = req.wdata & `SLD_REV_MASK;
        `SLD_OFF_RSV3: next_st.rsv3 = req.wdata;
        default: ;
      endcase
    end
    if (req.we && req.rtc_space && req.addr == `SLD_OFF_RTC_CLK) begin
      next_st.rtc_clk = req.wdata;
    end

    // Register reads, answered one cycle later
    next_st.rdata = 8'h00;
    if (req.re && req.rtc_space) begin
      next_st.rdata = (req.addr == `SLD_OFF_RTC_CLK) ? st.rtc_clk : 8'h00;
    end else if (req.re) begin
      unique case (req.addr)
        `SLD_OFF_CFG: next_st.rdata = st.cfg;
        `SLD_OFF_CLKB: next_st.rdata = st.clkb;
        `SLD_OFF_PIN: next_st.rdata = st.pin;
        `SLD_OFF_CONX: next_st.rdata = st.conx;
        `SLD_OFF_PTR: next_st.rdata = st.ptr;
        `SLD_OFF_DAT: next_st.rdata = st.dat;
        `SLD_OFF_CTLY: next_st.rdata = st.ctly;
        `SLD_OFF_REV: next_st.rdata = st.rev;
        `SLD_OFF_RSV3: next_st.rdata = st.rsv3;
        default: next_st.rdata = 8'h00;
      endcase
    end

    // Driver state
    next_active = st.cfg[`SLD_CFG_EN]
      && st.cfg[1:0] == `SLD_MUX_4X
      && !(st.cfg[`SLD_CFG_SLEEP] && sleep_power_state);
    next_st.active = next_active;
    next_st.pads_fn = 1'b1;

    // Levels: backplane selected or segment lit differs from the common phase
    inv = st.pol ^ (st.ctly[`SLD_CTLY_INV] & st.fpar);
    for (int c = 0; c < 4; c++) begin
      com_lvl[c] = (st.slot == 2'(c)) ^ inv;
    end
    for (int s = 0; s < 25; s++) begin
      seg_lvl[s] = (st.shadow[s / 2][(s % 2) * 4 + int'(st.slot)] & vis) ^ inv;
    end
    for (int c = 0; c < 4; c++) begin
      com_o[c] = st.rev[`SLD_REV_COM] ? com_lvl[3 - c] : com_lvl[c];
    end
    for (int s = 0; s < 25; s++) begin
      seg_o[s] = st.rev[`SLD_REV_SEG] ? seg_lvl[24 - s] : seg_lvl[s];
    end

    // Pin-out order
    next_st.pins = {com_o, seg_o};
    if (st.pin[`SLD_PIN_EN]) begin
      if (st.pin[6:4] == `SLD_SEQ_COM_FIRST) begin
        next_st.pins = {seg_o, com_o};
      end else if (st.pin[6:4] == `SLD_SEQ_SEG_DESC) begin
        for (int k = 0; k < 24; k++) begin
          next_st.pins[k] = seg_o[23 - k];
        end
        for (int k = 0; k < 4; k++) begin
          next_st.pins[24 + k] = com_o[3 - k];
        end
        next_st.pins[28] = seg_o[24];
      end
    end
    if (!next_active) begin
      next_st.pins = 29'h00000000;
    end
  end

  // ==========================================
  // State register
  always_ff @(posedge clock) begin
    if (!rstn) begin
      st <= '0;
      st.rtc_clk <= `SLD_RST_RTC_CLK;
      st.cfg <= `SLD_RST_CFG;
      st.clkb <= `SLD_RST_CLKB;
      st.pin <= `SLD_RST_PIN;
      st.conx <= `SLD_RST_CONX;
      st.ptr <= `SLD_RST_PTR;
      st.dat <= `SLD_RST_DAT;
      st.ctly <= `SLD_RST_CTLY;
      st.rev <= `SLD_RST_REV;
      st.rsv3 <= `SLD_RST_RSV3;
      st.pads_fn <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign panel_pins = st.pins;
  assign display_active = st.active;
  assign pads_display_fn = st.pads_fn;

  // ==========================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_mux_level_gate: assert property (st.cfg[1:0] != `SLD_MUX_4X |=> !st.active)
    else $error("driver active without four-way multiplexing");
  a_driver_off_pins: assert property (!st.cfg[`SLD_CFG_EN] |=> !st.active && st.pins == 29'h00000000)
    else $error("driver drives pins while disabled");
  a_mem_clear_all: assert property (req.we && !req.rtc_space && req.addr == `SLD_OFF_CFG
    && req.wdata[`SLD_CFG_CLR] |=> st.mem == '0 && !st.cfg[`SLD_CFG_CLR])
    else $error("display memory not cleared");
  a_sleep_forced_off: assert property (st.cfg[`SLD_CFG_SLEEP] && sleep_power_state |=> !st.active)
    else $error("display active in sleep with force-off set");
  a_clock_gate_off: assert property (!st.rtc_clk[3] |=> st.clk_cnt == 20'h00000 && $stable(st.half_cnt))
    else $error("display clock runs while deselected");
  a_half_slot_flip: assert property (half_end |=> st.pol != $past(st.pol))
    else $error("polarity missed a half-slot flip");
  a_hold_freeze: assert property (st.ctly[`SLD_CTLY_HOLD] && !(req.we && req.addr == `SLD_OFF_CTLY)
    |=> $stable(st.shadow))
    else $error("display changed while refresh hold set");
  a_ptr_store: assert property (req.we && !req.rtc_space && req.addr == `SLD_OFF_PTR
    && req.wdata[`SLD_PTR_WR] && req.wdata[6:0] <= `SLD_MEM_LAST
    |=> st.mem[$past(req.wdata[3:0])] == $past(st.dat))
    else $error("pointer write did not store data");
  a_ptr_load: assert property (req.we && !req.rtc_space && req.addr == `SLD_OFF_PTR
    && !req.wdata[`SLD_PTR_WR] && req.wdata[6:0] <= `SLD_MEM_LAST
    |=> st.dat == st.mem[$past(req.wdata[3:0])])
    else $error("pointer read did not load data");
  a_frame_latch: assert property (frame_end && !st.ctly[`SLD_CTLY_HOLD] |=> st.shadow == $past(st.mem))
    else $error("memory not taken at frame start");

endmodule

/* File: design/sld_params.svh */
// Constants for the segment display driver: offsets, fields, resets, timing
`ifndef SLD_PARAMS_SVH
`define SLD_PARAMS_SVH
// ==========================================
// Register offsets
`define SLD_OFF_RTC_CLK 8'h0F
`define SLD_OFF_CFG 8'hE5
`define SLD_OFF_CLKB 8'hE6
`define SLD_OFF_PIN 8'hE7
`define SLD_OFF_CONX 8'hE8
`define SLD_OFF_PTR 8'hF8
`define SLD_OFF_DAT 8'hF9
`define SLD_OFF_CTLY 8'hFA
`define SLD_OFF_REV 8'hFB
`define SLD_OFF_RSV3 8'hFC
// ==========================================
// Reset values
`define SLD_RST_RTC_CLK 8'h30
`define SLD_RST_CFG 8'h00
`define SLD_RST_CLKB 8'h00
`define SLD_RST_PIN 8'h00
`define SLD_RST_CONX 8'h40
`define SLD_RST_PTR 8'h00
`define SLD_RST_DAT 8'h00
`define SLD_RST_CTLY 8'h00
`define SLD_RST_REV 8'h00
`define SLD_RST_RSV3 8'h00
// ==========================================
// Field positions and codes
`define SLD_CFG_EN 7
`define SLD_CFG_CLR 6
`define SLD_CFG_BLINK 5
`define SLD_CFG_SLEEP 4
`define SLD_CFG_MASK 8'hF3
`define SLD_MUX_4X 2'h3
`define SLD_CLKB_MASK 8'hCF
`define SLD_BLK_2HZ 2'h2
`define SLD_BLK_EXT 2'h3
`define SLD_PIN_EN 7
`define SLD_PIN_MASK 8'hF0
`define SLD_SEQ_COM_FIRST 3'h6
`define SLD_SEQ_SEG_DESC 3'h7
`define SLD_CTLY_INV 6
`define SLD_CTLY_HOLD 0
`define SLD_CTLY_MASK 8'h41
`define SLD_REV_SEG 3
`define SLD_REV_COM 2
`define SLD_REV_MASK 8'h0C
`define SLD_CKSEL_RATE 2'h2
`define SLD_CKSEL_128 2'h3
`define SLD_PTR_WR 7
`define SLD_MEM_LAST 7'h0C
// ==========================================
// Timing
`define SLD_CLK_HZ 125000000
`define SLD_F128_HZ 128
`define SLD_F1024_HZ 1024
`define SLD_F2048_HZ 2048
`define SLD_F4096_HZ 4096
`define SLD_F8192_HZ 8192
`define SLD_BLINK_HZ 2
`define SLD_HALF_FD0 6'h20
`endif

/* File: design/sld_pkg.sv */
// Types shared by the segment display driver
package sld_pkg;
  // Register-bus request from the processor core
  typedef struct packed {
    logic rtc_space;
    logic we;
    logic re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sld_req_t;

  // Whole state of the driver
  typedef struct packed {
    logic [7:0] rtc_clk;
    logic [7:0] cfg;
    logic [7:0] clkb;
    logic [7:0] pin;
    logic [7:0] conx;
    logic [7:0] ptr;
    logic [7:0] dat;
    logic [7:0] ctly;
    logic [7:0] rev;
    logic [7:0] rsv3;
    logic [12:0][7:0] mem;
    logic [12:0][7:0] shadow;
    logic [19:0] clk_cnt;
    logic [5:0] half_cnt;
    logic [1:0] slot;
    logic pol;
    logic fpar;
    logic [24:0] blink_cnt;
    logic blink_vis;
    logic ext_s1;
    logic ext_s2;
    logic active;
    logic pads_fn;
    logic [28:0] pins;
    logic [7:0] rdata;
  } sld_state_t;
endpackage

/* File: design/sld_unused_none.sv */
// Intentionally empty: the whole driver lives in the main design file

/* File: verification/sld_driver_tb.sv */
// Self-checking testbench for the segment display driver
module sld_driver_tb
  import sld_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'h0;
  logic rstn = 1'h0;
  sld_req_t req = '0;
  logic sleep_power_state = 1'h0;
  logic external_blink_time = 1'h0;
  logic [7:0] rdata;
  logic [28:0] panel_pins;
  logic display_active;
  logic pads_display_fn;
  int toggles;
  int interval;
  int dc;
  int n_fail = 0;
  int comparisons = 0;
  // Cycles per display tick for 128, 1024, 2048, 4096, 8192 Hz and per blink half
  localparam int SHORT_CYC [6] = '{5, 6, 3, 2, 1, 16};
  localparam logic [7:0] OFFS [9] = '{8'hE5, 8'hE6, 8'hE7, 8'hE8, 8'hF8, 8'hF9, 8'hFA, 8'hFB, 8'hFC};
  localparam logic [7:0] RSTV [9] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] MSK [9] = '{8'hB3, 8'hCF, 8'hF0, 8'hFF, 8'hFF, 8'hFF, 8'h41, 8'h0C, 8'hFF};
  // Clock select, divider code, expected half slot in system cycles
  localparam logic [23:0] RATES [9] = '{24'h080209, 24'h080109, 24'h080060, 24'h080F30, 24'h090212,
    24'h0A0206, 24'h0B0203, 24'h0C020F, 24'h0D020F};
  // Pin order, reverse bits, key pin, expected image
  localparam logic [55:0] ORD [5] = '{56'h0000190200_0001, 56'h0008190300_0000, 56'h00041C1000_0001,
    56'hE000000000_0011, 56'hF0001C1000_0000};

  always #4 clock = ~clock;

  // Short counts keep every frame within a few hundred cycles
  sld_driver #(
    .CYC_128(SHORT_CYC[0]),
    .CYC_1024(SHORT_CYC[1]),
    .CYC_2048(SHORT_CYC[2]),
    .CYC_4096(SHORT_CYC[3]),
    .CYC_8192(SHORT_CYC[4]),
    .CYC_BLINK_HALF(SHORT_CYC[5])
  ) i_dut (
    .clock(clock),
    .rstn(rstn),
    .req(req),
    .rdata(rdata),
    .sleep_power_state(sleep_power_state),
    .external_blink_time(external_blink_time),
    .panel_pins(panel_pins),
    .display_active(display_active),
    .pads_display_fn(pads_display_fn)
  );

  sld_glass i_glass (
    .clock(clock),
    .pins(panel_pins),
    .toggles(toggles),
    .interval(interval),
    .dc(dc)
  );

  // ==========================================
  // Checking and closing
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========================================
  // Register bus cycles
  task automatic wr(input logic rs, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{rtc_space: rs, we: 1'h1, re: 1'h0, addr: a, wdata: d};
    @(posedge clock);
    req <= '0;
  endtask

  task automatic rd(input logic rs, input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clock);
    req <= '{rtc_space: rs, we: 1'h0, re: 1'h1, addr: a, wdata: 8'h00};
    @(posedge clock);
    req <= '0;
    #1;
    chk(what, rdata, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Image with polarity removed, taken when the key pin is lit
  task automatic snap(input int key, input logic [28:0] mask, input logic [28:0] exp, input string what);
    logic [28:0] img;
    int i;
    cyc(3);
    for (i = 0; i < 400; i++) begin
      img = panel_pins ^ {29{panel_pins[5]}};
      if (img[key]) break;
      cyc(1);
    end
    chk(what, {3'h0, img & mask}, {3'h0, exp});
    if (i == 400) close_out();
  endtask

  initial begin
    int i;
    int t0;
    int d0;
    repeat (12) @(posedge clock);
    rstn <= 1'h1;
    cyc(1);
    // ==========================================
    // Register reset values and writable bits
    chk("pads function", pads_display_fn, 1);
    chk("active at reset", display_active, 0);
    rd(1'h1, 8'h0F, 8'h30, "clock select reset");
    for (i = 0; i < 9; i++) rd(1'h0, OFFS[i], RSTV[i], "reset value");
    for (i = 0; i < 9; i++) wr(1'h0, OFFS[i], 8'hFF);
    wr(1'h0, 8'hE9, 8'hFF);
    for (i = 0; i < 9; i++) rd(1'h0, OFFS[i], MSK[i], "written value");
    rd(1'h0, 8'hE9, 8'h00, "unmapped");
    for (i = 0; i < 9; i++) wr(1'h0, OFFS[i], 8'h00);
    $display("test registers done");
    // ==========================================
    // Display memory through pointer and data
    wr(1'h0, 8'hF9, 8'hA5);
    wr(1'h0, 8'hF8, 8'h8C);
    wr(1'h0, 8'hF9, 8'h00);
    wr(1'h0, 8'hF8, 8'h0C);
    rd(1'h0, 8'hF9, 8'hA5, "memory readback");
    wr(1'h0, 8'hF8, 8'h0D);
    rd(1'h0, 8'hF9, 8'h00, "beyond memory");
    wr(1'h0, 8'hE5, 8'h40);
    wr(1'h0, 8'hF8, 8'h0C);
    rd(1'h0, 8'hF9, 8'h00, "cleared memory");
    $display("test memory done");
    // ==========================================
    // Enable, multiplex level and sleep
    // Driver first, display clock last
    wr(1'h0, 8'hE5, 8'h80);
    wr(1'h0, 8'hE6, 8'h02);
    wr(1'h1, 8'h0F, 8'h08);
    cyc(3);
    chk("mux not four", display_active, 0);
    chk("idle pins", {3'h0, panel_pins}, 0);
    wr(1'h0, 8'hE5, 8'h93);
    sleep_power_state <= 1'h1;
    cyc(3);
    chk("sleep forced off", display_active, 0);
    wr(1'h0, 8'hE5, 8'h83);
    cyc(3);
    chk("sleep ignored", display_active, 1);
    wr(1'h0, 8'hE5, 8'h93);
    sleep_power_state <= 1'h0;
    cyc(3);
    chk("awake", display_active, 1);
    $display("test enable done");
    // ==========================================
    // Display clock and frame divider
    for (i = 0; i < 9; i++) begin
      wr(1'h1, 8'h0F, RATES[i][23:16]);
      wr(1'h0, 8'hE6, RATES[i][15:8]);
      cyc(250);
      chk("half slot", interval, RATES[i][7:0]);
    end
    wr(1'h1, 8'h0F, 8'h30);
    // Let a flip launched by the last tick reach the glass first
    cyc(3);
    t0 = toggles;
    cyc(200);
    chk("clock stopped", toggles - t0, 0);
    $display("test rates done");
    // ==========================================
    // Drive balance and frame inversion
    wr(1'h1, 8'h0F, 8'h08);
    wr(1'h0, 8'hE6, 8'h02);
    wr(1'h0, 8'hF9, 8'h01);
    wr(1'h0, 8'hF8, 8'h80);
    wr(1'h0, 8'hF9, 8'h02);
    wr(1'h0, 8'hF8, 8'h8C);
    for (i = 0; i < 2; i++) begin
      wr(1'h0, 8'hFA, {1'h0, i[0], 6'h00});
      cyc(200);
      t0 = toggles;
      d0 = dc;
      cyc(144);
      chk("inversions in two frames", toggles - t0, 16 - 2 * i);
      chk("net cell dc", dc - d0, 0);
    end
    wr(1'h0, 8'hFA, 8'h00);
    $display("test inversion done");
    // ==========================================
    // Pin order and reversal
    for (i = 0; i < 5; i++) begin
      wr(1'h0, 8'hE7, ORD[i][55:48]);
      wr(1'h0, 8'hFB, ORD[i][47:40]);
      snap(ORD[i][39:32], ORD[i][55:48] == 8'hF0 ? 29'h10FFFFFF : '1, ORD[i][28:0], "pin image");
    end
    wr(1'h0, 8'hE7, 8'h00);
    wr(1'h0, 8'hFB, 8'h00);
    $display("test pin order done");
    // ==========================================
    // Refresh hold
    wr(1'h0, 8'hFA, 8'h01);
    wr(1'h0, 8'hF9, 8'h00);
    wr(1'h0, 8'hF8, 8'h80);
    cyc(200);
    snap(25, '1, 29'h02000001, "held image");
    wr(1'h0, 8'hFA, 8'h00);
    cyc(200);
    snap(25, '1, 29'h02000000, "refreshed image");
    $display("test hold done");
    // ==========================================
    // Blink modes, external source held high
    wr(1'h0, 8'hF9, 8'h01);
    wr(1'h0, 8'hF8, 8'h80);
    wr(1'h0, 8'hE5, 8'hB3);
    external_blink_time <= 1'h1;
    for (i = 0; i < 4; i++) begin
      wr(1'h0, 8'hE6, {i[1:0], 6'h02});
      cyc(200);
      snap(i == 2 ? 0 : 25, '1, i == 3 ? 29'h02000000 : 29'h02000001, "blink image");
      if (i == 2) begin
        // The 2 Hz phase must blank the lit segment during some selected slot
        t0 = 0;
        repeat (200) begin
          cyc(1);
          if (panel_pins[25] != panel_pins[5] && panel_pins[0] == panel_pins[5]) begin
            t0++;
          end
        end
        chk("blink dark slot", t0 != 0, 1);
      end
    end
    external_blink_time <= 1'h0;
    cyc(200);
    snap(25, '1, 29'h02000001, "external shown");
    $display("test blink done");
    close_out();
  end
endmodule

/* File: verification/sld_glass.sv */
// Glass panel model: watches the drive pins, integrates cell DC and times inversions
module sld_glass #(
  parameter int REF = 5,
  parameter int FRONTPLANE_LINE = 0,
  parameter int BP = 25
) (
  // Clock
  input wire logic clock,
  // Drive from the display driver
  input wire logic [28:0] pins,
  // Observations
  output int toggles,
  output int interval,
  output int dc
);
  timeunit 1ns;
  timeprecision 1ps;
  int run = 0;
  logic last = 1'h0;

  initial begin
    toggles = 0;
    interval = 0;
    dc = 0;
  end

  // ==========================================
  // Cell between one segment and one backplane
  // Net charge builds up only if the drive is not balanced
  always @(posedge clock) begin
    // Each pin must spend as long high as low over whole frames
    dc <= dc + (pins[FRONTPLANE_LINE] ? 1 : -1) + (pins[BP] ? 1 : -1);
    run <= run + 1;
    last <= pins[REF];
    // An unlit segment follows the drive polarity alone
    if (pins[REF] != last) begin
      toggles <= toggles + 1;
      interval <= run;
      run <= 1;
    end
  end
endmodule
